//--- hw/twsp_port.sv
// two-wire serial port: register file, bus monitor, byte engine, master sequencer
`timescale 1ns/1ps
module twsp_port (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// special function register port
	input  wire twsp_pkg::twsp_sfr_req_t sfr_req,
	output logic [7:0]                   sfr_rdata_q,
	// timer overflow for the variable rate
	input  wire logic                    timer_ovf,
	// bus pins
	input  wire logic                    scl_i,
	input  wire logic                    sda_i,
	output twsp_pkg::twsp_bus_out_t      bus_q,
	// serial interrupt request
	output logic                         serial_irq_q
);

	twsp_pkg::twsp_mode_t    mode_q,   mode_d;
	twsp_pkg::twsp_mphase_t  mphase_q, mphase_d;
	twsp_pkg::twsp_bus_out_t bus_d;
	logic [7:0] rdata_d;
	logic [2:0] rate_q,   rate_d;
	logic       ens_q,    ens_d;
	logic       sta_q,    sta_d;
	logic       sto_q,    sto_d;
	logic       si_d;
	logic       si_past_q;
	logic       aa_q,     aa_d;
	logic [7:0] own_q,    own_d;
	logic [7:0] data_q,   data_d;
	logic [4:0] code_q,   code_d;
	logic [4:0] view_q,   view_d;
	logic [3:0] cnt_q,    cnt_d;
	logic [1:0] step_q,   step_d;
	logic       addr_q,   addr_d;
	logic       tx_q,     tx_d;
	logic       ack_q,    ack_d;
	logic       lost_q,   lost_d;
	logic       busy_q,   busy_d;
	logic       began_q,  began_d;
	logic       scl_p_q;
	logic       sda_p_q;
	logic [1:0] filt_q;
	logic       tick;

	// pin synchronisers: a change counts once stages two and three agree; see [R10]
	logic [1:0] pin_in;
	assign pin_in = {scl_i, sda_i};
	for (genvar i = 0; i < 2; i++) begin : g_sync
		logic [2:0] ff_q;
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				ff_q      <= 3'b111;
				filt_q[i] <= 1'b1;
			end else begin
				ff_q      <= {ff_q[1:0], pin_in[i]};
				filt_q[i] <= (ff_q[1] == ff_q[2]) ? ff_q[2] : filt_q[i];
			end
		end
	end

	logic scl_f;
	logic sda_f;
	assign scl_f = filt_q[1];
	assign sda_f = filt_q[0];

	twsp_rate_gen #(
		.CW (8)
	) u_rate (
		.clk       (clk),
		.resetn    (resetn),
		.run       (ens_q && (mphase_q != twsp_pkg::MP_IDLE)),
		.rate_sel  (rate_q),
		.timer_ovf (timer_ovf),
		.tick_q    (tick)
	);

	// register port and status view
	always_comb begin
		rdata_d = 8'h00;
		if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				twsp_pkg::ADDR_CTRL: rdata_d = {rate_q[2], ens_q, sta_q, sto_q,
				                                serial_irq_q, aa_q, rate_q[1:0]};
				twsp_pkg::ADDR_STAT: rdata_d = {view_q, 3'b000}; // see [R11]
				twsp_pkg::ADDR_DATA: rdata_d = data_q;
				twsp_pkg::ADDR_OWN:  rdata_d = own_q;
				default:             rdata_d = 8'h00;
			endcase
		end
		// code shows one cycle after the flag rises and lingers one after it falls; see [R13]
		if (serial_irq_q) begin
			view_d = code_q;
		end else if (si_past_q) begin
			view_d = view_q;
		end else begin
			view_d = twsp_pkg::ST_NONE[7:3];
		end
	end

	// control, byte engine and master sequencer
	logic       wr_ctrl;
	logic       rise;
	logic       fall;
	logic       start_det;
	logic       stop_det;
	logic       resume;
	logic       si_set;
	logic       acked;
	logic       own_hit;
	logic       gc_hit;
	logic [7:0] code8;

	always_comb begin
		mode_d   = mode_q;
		mphase_d = mphase_q;
		bus_d    = bus_q;
		rate_d   = rate_q;
		ens_d    = ens_q;
		sta_d    = sta_q;
		sto_d    = sto_q;
		aa_d     = aa_q;
		own_d    = own_q;
		data_d   = data_q;
		code_d   = code_q;
		cnt_d    = cnt_q;
		step_d   = step_q;
		addr_d   = addr_q;
		tx_d     = tx_q;
		ack_d    = ack_q;
		lost_d   = lost_q;
		busy_d   = busy_q;
		began_d  = began_q;
		si_set   = 1'b0;
		code8    = twsp_pkg::ST_NONE;
		wr_ctrl  = sfr_req.wr && (sfr_req.addr == twsp_pkg::ADDR_CTRL);
		rise     = scl_f && !scl_p_q;
		fall     = !scl_f && scl_p_q;
		start_det = scl_f && scl_p_q && sda_p_q && !sda_f;
		stop_det  = scl_f && scl_p_q && !sda_p_q && sda_f;
		resume   = si_past_q && !serial_irq_q;
		acked    = !ack_q; // see [R22]
		own_hit  = data_q[7:1] == own_q[7:1];
		gc_hit   = (data_q == 8'h00) && own_q[twsp_pkg::B_GC]; // see [R24]

		if (wr_ctrl) begin
			rate_d = {sfr_req.wdata[twsp_pkg::B_CR2], sfr_req.wdata[twsp_pkg::B_CR1],
			          sfr_req.wdata[twsp_pkg::B_CR0]};
			ens_d  = sfr_req.wdata[twsp_pkg::B_ENS];
			sta_d  = sfr_req.wdata[twsp_pkg::B_STA];
			aa_d   = sfr_req.wdata[twsp_pkg::B_AA]; // see [R04]
		end
		if (sfr_req.wr && (sfr_req.addr == twsp_pkg::ADDR_OWN)) begin
			own_d = sfr_req.wdata;
		end
		// data is written only while the shifter is parked
		if (sfr_req.wr && (sfr_req.addr == twsp_pkg::ADDR_DATA) && (serial_irq_q || !busy_q)) begin
			data_d = sfr_req.wdata;
		end

		if (!ens_q) begin
			mode_d   = twsp_pkg::MODE_NAS;
			mphase_d = twsp_pkg::MP_IDLE;
			bus_d    = '0;
			sto_d    = 1'b0;
			cnt_d    = 4'd0;
			busy_d   = 1'b0;
			lost_d   = 1'b0;
			began_d  = 1'b0;
		end else begin
			// byte engine runs in every mode so the bus stays tracked; see [R06]
			if (rise) begin
				if (cnt_q < 4'd8) begin
					data_d = {data_q[6:0], sda_f};
					cnt_d  = cnt_q + 4'd1;
					if ((mphase_q == twsp_pkg::MP_RUN) && tx_q && !bus_q.sda_oe && !sda_f) begin
						lost_d   = 1'b1;
						tx_d     = 1'b0;
						mphase_d = twsp_pkg::MP_IDLE;
						mode_d   = twsp_pkg::MODE_NAS;
						began_d  = 1'b0;
						bus_d.scl_oe = 1'b0;
					end
				end else if (cnt_q == 4'd8) begin
					ack_d = sda_f;
					cnt_d = 4'd9;
				end
			end
			if (fall) begin
				if ((cnt_q != 4'd0) && (cnt_q < 4'd8)) begin
					bus_d.sda_oe = tx_q && !data_q[7];
				end else if (cnt_q == 4'd8) begin
					bus_d.sda_oe = 1'b0;
					if (tx_q) begin
						bus_d.sda_oe = 1'b0;
					end else if (addr_q && (mphase_q == twsp_pkg::MP_IDLE) &&
					             (mode_q == twsp_pkg::MODE_NAS)) begin
						// enable is sampled at the end of the byte; see [R07]
						if (aa_q && (own_hit || gc_hit)) begin // see [R01] see [R05] see [R16]
							bus_d.sda_oe = 1'b1;
							if (gc_hit) begin
								mode_d = twsp_pkg::MODE_SRX_GC;
							end else if (data_q[0]) begin
								mode_d = twsp_pkg::MODE_STX;
								tx_d   = 1'b1;
							end else begin
								mode_d = twsp_pkg::MODE_SRX;
							end
						end
					end else if ((mode_q == twsp_pkg::MODE_MRX) || (mode_q == twsp_pkg::MODE_SRX) ||
					             (mode_q == twsp_pkg::MODE_SRX_GC)) begin
						bus_d.sda_oe = aa_q; // see [R01] see [R02]
					end
				end else if (cnt_q == 4'd9) begin
					cnt_d  = 4'd0;
					addr_d = 1'b0;
					bus_d.sda_oe = 1'b0;
					if (mphase_q == twsp_pkg::MP_RUN) begin
						si_set = 1'b1;
						if (addr_q) begin
							// see [R19] see [R20]
							mode_d = data_q[0] ? twsp_pkg::MODE_MRX : twsp_pkg::MODE_MTX;
							tx_d   = !data_q[0];
							if (data_q[0]) begin
								code8 = acked ? twsp_pkg::ST_AR_ACK : twsp_pkg::ST_AR_NACK;
							end else begin
								code8 = acked ? twsp_pkg::ST_AW_ACK : twsp_pkg::ST_AW_NACK;
							end
						end else if (mode_q == twsp_pkg::MODE_MTX) begin
							code8 = acked ? twsp_pkg::ST_DW_ACK : twsp_pkg::ST_DW_NACK;
						end else begin
							code8 = bus_q.sda_oe ? twsp_pkg::ST_DR_ACK : twsp_pkg::ST_DR_NACK;
						end
					end else begin
						si_set = 1'b1;
						lost_d = 1'b0;
						unique case (mode_q)
							twsp_pkg::MODE_NAS: begin
								si_set = lost_q; // see [R05]
								code8  = twsp_pkg::ST_ARB_LOST;
							end
							twsp_pkg::MODE_SRX: begin
								if (addr_q) begin
									code8 = lost_q ? twsp_pkg::ST_SW_OWN_ARB : twsp_pkg::ST_SW_OWN;
								end else begin
									code8 = bus_q.sda_oe ? twsp_pkg::ST_SD_ACK : twsp_pkg::ST_SD_NACK;
									mode_d = bus_q.sda_oe ? mode_q : twsp_pkg::MODE_NAS;
								end
							end
							twsp_pkg::MODE_SRX_GC: begin
								if (addr_q) begin
									code8 = lost_q ? twsp_pkg::ST_SW_GC_ARB : twsp_pkg::ST_SW_GC;
								end else begin
									code8 = bus_q.sda_oe ? twsp_pkg::ST_GD_ACK : twsp_pkg::ST_GD_NACK;
									mode_d = bus_q.sda_oe ? mode_q : twsp_pkg::MODE_NAS;
								end
							end
							twsp_pkg::MODE_STX: begin
								if (addr_q) begin
									code8 = lost_q ? twsp_pkg::ST_SR_OWN_ARB : twsp_pkg::ST_SR_OWN;
								end else if (!acked) begin
									code8  = twsp_pkg::ST_ST_NACK;
									mode_d = twsp_pkg::MODE_NAS;
									tx_d   = 1'b0;
								end else if (aa_q) begin
									code8 = twsp_pkg::ST_ST_ACK;
								end else begin
									code8  = twsp_pkg::ST_ST_LAST; // see [R03]
									mode_d = twsp_pkg::MODE_STX_LAST;
								end
							end
							default: si_set = 1'b0;
						endcase
					end
				end
			end

			// start and stop seen on the bus
			if (start_det) begin
				busy_d = 1'b1;
				cnt_d  = 4'd0;
				addr_d = 1'b1;
				if (mphase_q == twsp_pkg::MP_IDLE) begin
					if ((mode_q == twsp_pkg::MODE_SRX) || (mode_q == twsp_pkg::MODE_SRX_GC)) begin
						si_set = 1'b1;
						code8  = twsp_pkg::ST_SLV_END;
					end
					mode_d = twsp_pkg::MODE_NAS;
					tx_d   = 1'b0;
					bus_d.sda_oe = 1'b0;
				end
			end
			if (stop_det) begin
				busy_d = 1'b0;
				sto_d  = 1'b0;
				if (mphase_q == twsp_pkg::MP_IDLE) begin
					if ((mode_q == twsp_pkg::MODE_SRX) || (mode_q == twsp_pkg::MODE_SRX_GC)) begin
						si_set = 1'b1;
						code8  = twsp_pkg::ST_SLV_END;
					end
					mode_d = twsp_pkg::MODE_NAS;
					tx_d   = 1'b0;
					bus_d.sda_oe = 1'b0;
				end
			end

			// software cleared the flag: carry on, stop or restart; see [R14]
			if (resume) begin
				if (mphase_q == twsp_pkg::MP_RUN) begin
					if (sto_q) begin
						mphase_d = twsp_pkg::MP_STOP;
						step_d   = 2'd0;
					end else if (sta_q) begin
						mphase_d = twsp_pkg::MP_START;
						step_d   = 2'd0;
					end else begin
						bus_d.sda_oe = tx_q && !data_q[7];
					end
				end else if (sto_q) begin
					// slave recovery: act as if a stop arrived, nothing driven
					mode_d = twsp_pkg::MODE_NAS;
					sto_d  = 1'b0;
					tx_d   = 1'b0;
					bus_d.sda_oe = 1'b0;
				end else if (mode_q == twsp_pkg::MODE_STX) begin
					bus_d.sda_oe = !data_q[7];
				end else if (mode_q == twsp_pkg::MODE_STX_LAST) begin
					mode_d = twsp_pkg::MODE_NAS; // see [R03]
					tx_d   = 1'b0;
					bus_d.sda_oe = 1'b0;
				end
			end

			// master sequencer, one step per quarter bit
			unique case (mphase_q)
				twsp_pkg::MP_IDLE: begin
					// slave stretch: only pull a line that is already low; see [R23]
					bus_d.scl_oe = (serial_irq_q || si_past_q) && (bus_q.scl_oe || !scl_f);
					if (sta_q && !busy_q && !serial_irq_q && (mode_q == twsp_pkg::MODE_NAS)) begin
						mphase_d = twsp_pkg::MP_START; // see [R17]
						step_d   = 2'd0;
					end
				end
				twsp_pkg::MP_START: begin
					if (tick) begin
						unique case (step_q)
							2'd0: begin
								bus_d.sda_oe = 1'b0;
								step_d = 2'd1;
							end
							2'd1: begin
								bus_d.scl_oe = 1'b0;
								step_d = scl_f ? 2'd2 : 2'd1;
							end
							2'd2: begin
								bus_d.sda_oe = 1'b1;
								step_d = 2'd3;
							end
							2'd3: begin
								bus_d.scl_oe = 1'b1;
								mphase_d = twsp_pkg::MP_RUN;
								mode_d   = twsp_pkg::MODE_MTX;
								step_d   = 2'd0;
								cnt_d    = 4'd0;
								addr_d   = 1'b1;
								tx_d     = 1'b1;
								began_d  = 1'b1;
								si_set   = 1'b1;
								code8    = began_q ? twsp_pkg::ST_RSTART : twsp_pkg::ST_START;
							end
						endcase
					end
				end
				twsp_pkg::MP_RUN: begin
					// parked low while the flag is up; waits out a slave stretch
					if (tick && !serial_irq_q && !si_past_q) begin
						unique case (step_q)
							2'd0: step_d = 2'd1;
							2'd1: begin
								bus_d.scl_oe = 1'b0;
								step_d = 2'd2;
							end
							2'd2: step_d = scl_f ? 2'd3 : 2'd2;
							2'd3: begin
								bus_d.scl_oe = 1'b1;
								step_d = 2'd0;
							end
						endcase
					end
				end
				twsp_pkg::MP_STOP: begin
					if (tick) begin
						unique case (step_q)
							2'd0: begin
								bus_d.sda_oe = 1'b1;
								step_d = 2'd1;
							end
							2'd1: begin
								bus_d.scl_oe = 1'b0;
								step_d = scl_f ? 2'd2 : 2'd1;
							end
							2'd2: begin
								bus_d.sda_oe = 1'b0;
								step_d = 2'd3;
							end
							2'd3: begin
								sto_d    = 1'b0;
								began_d  = 1'b0;
								mode_d   = twsp_pkg::MODE_NAS;
								tx_d     = 1'b0;
								step_d   = 2'd0;
								mphase_d = sta_q ? twsp_pkg::MP_START : twsp_pkg::MP_IDLE;
							end
						endcase
					end
				end
			endcase
		end

		// a software set of the stop request is never lost to a hardware clear
		if (wr_ctrl && sfr_req.wdata[twsp_pkg::B_STO] && sfr_req.wdata[twsp_pkg::B_ENS]) begin
			sto_d = 1'b1;
		end
		if (si_set) begin
			code_d = code8[7:3];
		end
		// hardware set beats a software clear in the same cycle; see [R12]
		si_d = si_set || (serial_irq_q && !(wr_ctrl && !sfr_req.wdata[twsp_pkg::B_SI]));
		bus_d.scl_o = 1'b0;
		bus_d.sda_o = 1'b0;
	end

	// one reset puts everything back to the unaddressed slave; see [R25]
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_q       <= twsp_pkg::MODE_NAS;
			mphase_q     <= twsp_pkg::MP_IDLE;
			bus_q        <= '0;
			sfr_rdata_q  <= 8'h00;
			rate_q       <= {twsp_pkg::CTRL_RST[twsp_pkg::B_CR2], twsp_pkg::CTRL_RST[1:0]};
			ens_q        <= twsp_pkg::CTRL_RST[twsp_pkg::B_ENS];
			sta_q        <= twsp_pkg::CTRL_RST[twsp_pkg::B_STA];
			sto_q        <= twsp_pkg::CTRL_RST[twsp_pkg::B_STO];
			serial_irq_q <= twsp_pkg::CTRL_RST[twsp_pkg::B_SI];
			aa_q         <= twsp_pkg::CTRL_RST[twsp_pkg::B_AA];
			si_past_q    <= 1'b0;
			own_q        <= twsp_pkg::OWN_RST;
			data_q       <= twsp_pkg::DATA_RST;
			code_q       <= twsp_pkg::ST_NONE[7:3];
			view_q       <= twsp_pkg::ST_NONE[7:3];
			cnt_q        <= 4'd0;
			step_q       <= 2'd0;
			addr_q       <= 1'b0;
			tx_q         <= 1'b0;
			ack_q        <= 1'b1;
			lost_q       <= 1'b0;
			busy_q       <= 1'b0;
			began_q      <= 1'b0;
			scl_p_q      <= 1'b1;
			sda_p_q      <= 1'b1;
		end else begin
			mode_q       <= mode_d;
			mphase_q     <= mphase_d;
			bus_q        <= bus_d;
			sfr_rdata_q  <= rdata_d;
			rate_q       <= rate_d;
			ens_q        <= ens_d;
			sta_q        <= sta_d;
			sto_q        <= sto_d;
			serial_irq_q <= si_d;
			aa_q         <= aa_d;
			si_past_q    <= serial_irq_q;
			own_q        <= own_d;
			data_q       <= data_d;
			code_q       <= code_d;
			view_q       <= view_d;
			cnt_q        <= cnt_d;
			step_q       <= step_d;
			addr_q       <= addr_d;
			tx_q         <= tx_d;
			ack_q        <= ack_d;
			lost_q       <= lost_d;
			busy_q       <= busy_d;
			began_q      <= began_d;
			scl_p_q      <= scl_f;
			sda_p_q      <= sda_f;
		end
	end

endmodule // twsp_port

//--- hw/twsp_rate_gen.sv
// quarter-bit tick generator for the master serial clock
`timescale 1ns/1ps
module twsp_rate_gen #(
	parameter int CW = 8
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// control
	input  wire logic       run,
	input  wire logic [2:0] rate_sel,
	input  wire logic       timer_ovf,
	// tick out
	output logic            tick_q
);

	if (CW < 8) begin : g_bad_width
		$error("twsp_rate_gen: CW too small for the largest divisor");
	end

	localparam logic [1:0] OVF_LAST = 2'(twsp_pkg::OVF_PER_QUARTER - 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [1:0]    ovf_q;
	logic [1:0]    ovf_d;
	logic          tick_d;
	logic [CW-1:0] reload;

	always_comb begin
		reload = CW'(twsp_pkg::RATE_DIV[rate_sel] / twsp_pkg::QUARTERS_PER_BIT - 1);
		tick_d = 1'b0;
		cnt_d  = cnt_q;
		ovf_d  = ovf_q;
		if (!run) begin
			cnt_d = '0;
			ovf_d = '0;
		end else if (rate_sel == twsp_pkg::RATE_TIMER) begin
			// eight overflows make one bit, two per quarter; see [R09]
			if (timer_ovf) begin
				if (ovf_q == OVF_LAST) begin
					ovf_d  = '0;
					tick_d = 1'b1;
				end else begin
					ovf_d = ovf_q + 2'd1;
				end
			end
		end else if (cnt_q == '0) begin
			cnt_d  = reload; // see [R08]
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q  <= '0;
			ovf_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			ovf_q  <= ovf_d;
			tick_q <= tick_d;
		end
	end

endmodule // twsp_rate_gen

//--- inc/twsp_pkg.sv
// constants, types and status codes of the two-wire serial port
// How it works
// [R01] acknowledge own, general-call, received data when enabled
// [R02] not-acknowledge received data when acknowledge disabled
// [R03] after last slave byte, release to unaddressed
// [R04] software may re-enable acknowledge during last-byte state
// [R05] unaddressed slave ignores addresses, no acknowledge, no flag
// [R06] released unit still tracks start, stop, data
// [R07] late acknowledge enable still recognises address
// [R08] rate select divides oscillator for master clock
// [R09] rate select all ones uses timer overflows
// [R10] slave follows any incoming clock up to 100kHz
// [R11] status reads five code bits, low three zero
// [R12] idle code raises no flag; others do
// [R13] status valid one cycle after flag edges
// [R14] transfer waits until software clears flag
// [R15] software sets enable, clears start/stop/flag first
// [R16] acknowledge disabled means no slave entry
// [R17] start request waits free bus, reports 08H
// [R18] software loads target address plus write
// [R19] address byte done reports master or slave code
// [R20] read address after repeated start selects receiver
// [R21] receiver set up like transmitter, address plus read
// [R22] read/not-ack high, write/ack low, 8-bit bytes
// [R23] flag stretches clock low, high untouched
// [R24] own address upper seven, lowest enables general call
// [R25] single clock, one reset to unaddressed slave
package twsp_pkg;

	// register addresses
	localparam logic [7:0] ADDR_CTRL = 8'hD8;
	localparam logic [7:0] ADDR_STAT = 8'hD9;
	localparam logic [7:0] ADDR_DATA = 8'hDA;
	localparam logic [7:0] ADDR_OWN  = 8'hDB;

	// control register fields, and the general-call enable bit of the own address register
	localparam int B_CR2 = 7;
	localparam int B_ENS = 6;
	localparam int B_STA = 5;
	localparam int B_STO = 4;
	localparam int B_SI  = 3;
	localparam int B_AA  = 2;
	localparam int B_CR1 = 1;
	localparam int B_CR0 = 0;
	localparam int B_GC  = 0;

	// values after reset
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OWN_RST  = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;

	// clock rates
	localparam int unsigned OSC_HZ           = 100_000_000;
	localparam int unsigned SLAVE_MAX_HZ     = 100_000;
	localparam int unsigned QUARTERS_PER_BIT = 4;
	localparam int unsigned RATE_DIV [0:6]   = '{256, 224, 192, 160, 960, 120, 60};
	localparam logic [2:0]  RATE_TIMER       = 3'h7;
	localparam int unsigned TIMER_BIT_DIV    = 96;
	localparam int unsigned OSC_PER_TICK     = 12;
	localparam int unsigned OVF_PER_QUARTER  = TIMER_BIT_DIV / OSC_PER_TICK / QUARTERS_PER_BIT;

	// status codes
	localparam logic [7:0] ST_START      = 8'h08;
	localparam logic [7:0] ST_RSTART     = 8'h10;
	localparam logic [7:0] ST_AW_ACK     = 8'h18;
	localparam logic [7:0] ST_AW_NACK    = 8'h20;
	localparam logic [7:0] ST_DW_ACK     = 8'h28;
	localparam logic [7:0] ST_DW_NACK    = 8'h30;
	localparam logic [7:0] ST_ARB_LOST   = 8'h38;
	localparam logic [7:0] ST_AR_ACK     = 8'h40;
	localparam logic [7:0] ST_AR_NACK    = 8'h48;
	localparam logic [7:0] ST_DR_ACK     = 8'h50;
	localparam logic [7:0] ST_DR_NACK    = 8'h58;
	localparam logic [7:0] ST_SW_OWN     = 8'h60;
	localparam logic [7:0] ST_SW_OWN_ARB = 8'h68;
	localparam logic [7:0] ST_SW_GC      = 8'h70;
	localparam logic [7:0] ST_SW_GC_ARB  = 8'h78;
	localparam logic [7:0] ST_SD_ACK     = 8'h80;
	localparam logic [7:0] ST_SD_NACK    = 8'h88;
	localparam logic [7:0] ST_GD_ACK     = 8'h90;
	localparam logic [7:0] ST_GD_NACK    = 8'h98;
	localparam logic [7:0] ST_SLV_END    = 8'hA0;
	localparam logic [7:0] ST_SR_OWN     = 8'hA8;
	localparam logic [7:0] ST_SR_OWN_ARB = 8'hB0;
	localparam logic [7:0] ST_ST_ACK     = 8'hB8;
	localparam logic [7:0] ST_ST_NACK    = 8'hC0;
	localparam logic [7:0] ST_ST_LAST    = 8'hC8;
	localparam logic [7:0] ST_NONE       = 8'hF8;

	typedef enum logic [2:0] {
		MODE_NAS, MODE_MTX, MODE_MRX, MODE_SRX, MODE_SRX_GC, MODE_STX, MODE_STX_LAST
	} twsp_mode_t;

	typedef enum logic [1:0] {MP_IDLE, MP_START, MP_RUN, MP_STOP} twsp_mphase_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} twsp_sfr_req_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} twsp_bus_out_t;

endpackage

//--- testbench/tb.sv
// self-checking bench: master writes and reads against a slave model
`timescale 1ns/1ps
module tb;
	localparam logic [6:0] TGT = 7'h2A;
	localparam int         RLD = 254;
	logic                    clk, resetn, timer_ovf, serial_irq_q, slv_oe;
	twsp_pkg::twsp_sfr_req_t sfr_req;
	twsp_pkg::twsp_bus_out_t bus_q;
	logic [7:0]              sfr_rdata_q, rx_byte, tx_byte, v, d;
	logic [31:0]             seed;
	logic [2:0]              r;
	int                      mismatches, samples_checked, cyc, per, t_last, ov;
	wire                     scl, sda;
	assign scl = !bus_q.scl_oe;
	assign sda = !(bus_q.sda_oe || slv_oe);
	twsp_port uut (.clk(clk), .resetn(resetn), .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q),
		.timer_ovf(timer_ovf), .scl_i(scl), .sda_i(sda), .bus_q(bus_q),
		.serial_irq_q(serial_irq_q));
	twsp_slave_model #(.ADDR(TGT)) u_slave (.scl(scl), .sda(sda), .tx_byte(tx_byte),
		.sda_oe(slv_oe), .rx_byte(rx_byte));
	always #5 clk = !clk;
	always @(posedge scl) begin
		per = cyc - t_last;
		t_last = cyc;
	end
	always @(negedge clk) begin
		cyc = cyc + 1;
		ov = (ov + 1) % (12 * (256 - RLD));
		timer_ovf = ov == 0;
		if (cyc == 60000) begin
			mismatches++;
			finish_test();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int div_of(input logic [2:0] sel);
		int t [0:6] = '{256, 224, 192, 160, 960, 120, 60};
		return (sel == 3'h7) ? 96 * (256 - RLD) : t[sel];
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] wd);
		@(negedge clk);
		sfr_req = '{addr: a, wr: w, rd: !w, wdata: wd};
		@(negedge clk);
		v = sfr_rdata_q;
		sfr_req.wr = 0;
		sfr_req.rd = 0;
	endtask
	// optional data load, control write that clears the flag, then wait for the next code
	task automatic xfer(input logic ld, input logic [7:0] dat, fl, code);
		if (ld) acc(8'hDA, 1, dat);
		acc(8'hD8, 1, fl | {r[2], 5'h00, r[1:0]});
		while (serial_irq_q !== 1'b1) @(negedge clk);
		acc(8'hD9, 0, 8'h00);
		chk(v, code);
		if (code != 8'h08 && code != 8'h10) chk(8'(per == div_of(r)), 8'h01);
	endtask
	task automatic finish_test();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		{clk, resetn, timer_ovf, tx_byte, sfr_req} = '0;
		{mismatches, samples_checked, cyc, per, t_last, ov} = '0;
		seed = 32'h56c2_d7cf;
		repeat (20) @(negedge clk);
		resetn = 1;
		acc(8'hD8, 0, 8'h00);
		chk(v, 8'h00);
		acc(8'hD9, 0, 8'h00);
		chk(v, 8'hF8);
		acc(8'hDB, 1, {TGT ^ 7'h55, 1'b1});
		acc(8'hDB, 0, 8'h00);
		chk(v, {TGT ^ 7'h55, 1'b1});
		r = 3'h4;
		xfer(0, 8'h00, 8'h64, 8'h08);
		repeat (300) @(negedge clk);
		chk({7'h00, scl}, 8'h00);
		xfer(1, {TGT, 1'b0}, 8'h44, 8'h18);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			r = (seed[10:8] == 3'h4 || seed[10:8] == 3'h7) ? 3'h6 : seed[10:8];
			d = seed[7:0];
			xfer(1, d, 8'h44, 8'h28);
			chk(rx_byte, d);
		end
		xfer(0, 8'h00, 8'h64, 8'h10);
		xfer(1, {TGT ^ 7'h01, 1'b0}, 8'h44, 8'h20);
		xfer(0, 8'h00, 8'h74, 8'h08);
		// the slave puts out bit 7 on the address-ack fall, so the byte is set before it
		seed = lfsr(seed);
		tx_byte = seed[7:0];
		xfer(1, {TGT, 1'b1}, 8'h44, 8'h40);
		r = 3'h7;
		xfer(0, 8'h00, 8'h44, 8'h50);
		acc(8'hDA, 0, 8'h00);
		chk(v, tx_byte);
		r = 3'h6;
		xfer(0, 8'h00, 8'h40, 8'h58);
		acc(8'hD8, 1, 8'h50);
		repeat (600) @(negedge clk);
		chk({7'h00, serial_irq_q}, 8'h00);
		acc(8'hD9, 0, 8'h00);
		chk(v, 8'hF8);
		acc(8'hD8, 0, 8'h00);
		chk(v, 8'h40);
		acc(8'hD8, 1, 8'h44);
		acc(8'hD8, 0, 8'h00);
		chk(v, 8'h44);
		finish_test();
	end
endmodule // tb

//--- testbench/twsp_monitor.sv
// assertions on the two-wire port register reads and bus pins
`timescale 1ns/1ps
module twsp_monitor (
	// clock and reset
	input wire logic                    clk,
	input wire logic                    resetn,
	// watched ports
	input wire twsp_pkg::twsp_sfr_req_t sfr_req,
	input wire logic [7:0]              sfr_rdata_q,
	input wire twsp_pkg::twsp_bus_out_t bus_q,
	input wire logic                    serial_irq_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic rd, rs, rc, si, wcl;
	assign rd = sfr_req.rd;
	assign rs = rd && sfr_req.addr == 8'hD9;
	assign rc = rd && sfr_req.addr == 8'hD8;
	assign si = serial_irq_q;
	assign wcl = sfr_req.wr && sfr_req.addr == 8'hD8 && !sfr_req.wdata[3];
	a_idle_rd_zero: assert property (!rd |=> sfr_rdata_q == 8'h00)
		else $error("read data not cleared");
	a_unmapped_zero: assert property (rd && sfr_req.addr[7:2] != 6'h36 |=> !sfr_rdata_q)
		else $error("unmapped read not zero");
	a_stat_low_zero: assert property (rs |=> sfr_rdata_q[2:0] == 3'h0)
		else $error("status low bits set");
	a_stat_no_info: assert property (rs && !si && !$past(si) && !$past(si, 2) |=>
		sfr_rdata_q == 8'hF8) else $error("status not idle code");
	a_stat_valid: assert property (rs && si && $past(si) && $past(si, 2) |=>
		sfr_rdata_q != 8'hF8) else $error("status code missing");
	a_ctrl_flag_bit: assert property (rc |=> sfr_rdata_q[3] == $past(si))
		else $error("flag bit wrong");
	a_flag_sw_clear: assert property ($fell(si) |-> $past(wcl))
		else $error("flag cleared without write");
	a_flag_stretch: assert property (si [*3] |-> bus_q.scl_oe)
		else $error("clock not stretched");
	a_open_drain: assert property (!bus_q.scl_o && !bus_q.sda_o)
		else $error("pin driven high");
endmodule // twsp_monitor
bind twsp_port twsp_monitor u_mon (.clk(clk), .resetn(resetn), .sfr_req(sfr_req),
	.sfr_rdata_q(sfr_rdata_q), .bus_q(bus_q), .serial_irq_q(serial_irq_q));

//--- testbench/twsp_slave_model.sv
// behavioural bus slave: acks its address, takes or serves data bytes
`timescale 1ns/1ps
module twsp_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	// bus wires
	input wire logic       scl,
	input wire logic       sda,
	// data
	input wire logic [7:0] tx_byte,
	output logic           sda_oe,
	output logic [7:0]     rx_byte
);
	int         n;
	logic [7:0] sh;
	logic       act, first, hit, rd, run;
	initial begin
		{sda_oe, act, first, hit, rd, run, sh, rx_byte} = '0;
		n = 0;
	end
	always @(negedge sda) if (scl) begin
		act = 1;
		first = 1;
		n = -1;
		{hit, run, sda_oe} = 3'h0;
	end
	always @(posedge sda) if (scl) begin
		act = 0;
		sda_oe = 0;
	end
	// msb first; the ninth bit is the master's acknowledge
	always @(posedge scl) if (act) begin
		if (n < 8) sh = {sh[6:0], sda};
		else run = run && !sda;
	end
	// data changes well after the fall to keep hold time
	always @(negedge scl) if (act) begin
		n = n + 1;
		if (n == 9) begin
			n = 0;
			first = 0;
		end
		if (n == 8) begin
			if (first) begin
				hit = sh[7:1] == ADDR;
				rd = sh[0];
				run = hit && sh[0];
			end else if (hit && !rd) rx_byte = sh;
			sda_oe <= #103 hit && (first || !rd);
		end else sda_oe <= #103 run && !tx_byte[7 - n];
	end
endmodule // twsp_slave_model
